// *** dce_pkg.sv ***
// Constants and types of the DMA checksum engine.
// Assumes a 16-bit register offset space decoded from haddr[15:0].
`default_nettype none
package dce_pkg;
  // Register base offsets
  localparam logic [15:0] DCE_OFF_GCTL  = 16'h3000;
  localparam logic [15:0] DCE_OFF_STAT  = 16'h3010;
  localparam logic [15:0] DCE_OFF_EADDR = 16'h3020;
  localparam logic [15:0] DCE_OFF_CCTL  = 16'h3030;
  localparam logic [15:0] DCE_OFF_CDATA = 16'h3040;
  localparam logic [15:0] DCE_OFF_CXOR  = 16'h3050;
  // Alias offsets within a register slot
  localparam logic [3:0]  DCE_ALIAS_NONE = 4'h0;
  localparam logic [3:0]  DCE_ALIAS_CLR  = 4'h4;
  localparam logic [3:0]  DCE_ALIAS_SET  = 4'h8;
  localparam logic [3:0]  DCE_ALIAS_INV  = 4'hC;
  // Writable bits and reset value
  localparam logic [31:0] DCE_GCTL_WMASK = 32'h0000_9000;
  localparam logic [31:0] DCE_CCTL_WMASK = 32'h3900_1FE7;
  localparam logic [31:0] DCE_FULL_MASK  = 32'hFFFF_FFFF;
  localparam logic [31:0] DCE_REG_RESET  = 32'h0000_0000;
  // Field positions
  localparam int DCE_GCTL_ON    = 15;
  localparam int DCE_GCTL_SUSP  = 12;
  localparam int DCE_GCTL_BUSY  = 11;
  localparam int DCE_STAT_DIR   = 3;
  localparam int DCE_STAT_CH_LO = 0;
  localparam int DCE_CCTL_BORD  = 28;
  localparam int DCE_CCTL_WRORD = 27;
  localparam int DCE_CCTL_BREV  = 24;
  localparam int DCE_CCTL_POLY  = 8;
  localparam int DCE_CCTL_EN    = 7;
  localparam int DCE_CCTL_APP   = 6;
  localparam int DCE_CCTL_TYP   = 5;
  localparam int DCE_CCTL_CH    = 0;
  // Byte order encodings
  localparam logic [1:0]  DCE_BORD_NONE = 2'h0;
  localparam logic [1:0]  DCE_BORD_REV  = 2'h1;
  localparam logic [1:0]  DCE_BORD_HSW  = 2'h2;
  localparam logic [1:0]  DCE_BORD_BSW  = 2'h3;
  // AHB codes
  localparam logic [2:0]  DCE_HSIZE_WORD = 3'h2;
  localparam logic        DCE_HRESP_OKAY = 1'b0;
  // Stream and buffer shape
  localparam int DCE_DATA_W     = 32;
  localparam int DCE_CH_W       = 3;
  localparam int DCE_WORD_W     = 36;
  localparam int DCE_FIFO_DEPTH = 4;
  typedef enum logic [1:0] {
    DCE_ST_RUN  = 2'b01,
    DCE_ST_EMIT = 2'b10
  } dce_state_t;
endpackage : dce_pkg
`default_nettype wire

// *** dce_stream_if.sv ***
// Valid/ready stream carrier between the engine and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface dce_stream_if #(parameter int W = 36);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dce_stream_if
`default_nettype wire

// *** dce_fifo.sv ***
// Word FIFO with registered ready and valid.
// Assumes one clock; ready only depends on the stored count.
`timescale 1ns/10ps
`default_nettype none
module dce_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 4
) (
  input wire logic   clk,
  input wire logic   rstn,
  dce_stream_if.snk  wr,
  dce_stream_if.src  rd
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          ready_r;
  logic          valid_r;
  logic          push;
  logic          pop;

  assign push     = wr.valid && ready_r;
  assign pop      = rd.ready && valid_r;
  assign wr.ready = ready_r;
  assign rd.valid = valid_r;
  assign rd.data  = mem[rp_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r   <= '0;
      ready_r <= 1'b1;
      valid_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      ready_r <= (cnt_nxt != FULL_CNT);
      valid_r <= (cnt_nxt != '0);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == LAST_PTR) ? '0 : wp_r + PW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == LAST_PTR) ? '0 : rp_r + PW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= wr.data;
    end
  end
endmodule : dce_fifo
`default_nettype wire

// *** dce_engine.sv ***
// DMA checksum engine: AHB-Lite registers, input FIFO, checksum datapath.
// Assumes the DMA presents one channel word per beat, its last flag,
// and the start address of the selected channel's destination.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module dce_engine
  import dce_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        src_valid,
  output logic             src_ready,
  input  wire logic [31:0] src_data,
  input  wire logic [2:0]  src_chan,
  input  wire logic        src_last,
  input  wire logic [31:0] dst_start_addr,
  output logic             dst_valid,
  input  wire logic        dst_ready,
  output logic      [31:0] dst_data,
  output logic      [31:0] dst_addr,
  output logic             dst_is_sum,
  output logic      [2:0]  dst_chan,
  output logic             dst_last,
  input  wire logic        err_valid,
  input  wire logic        err_write,
  input  wire logic [2:0]  err_chan,
  input  wire logic [31:0] err_addr
);
  default clocking dce_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  dce_stream_if #(.W(DCE_WORD_W)) in_if ();
  dce_stream_if #(.W(DCE_WORD_W)) out_if ();

  logic [31:0] gctl_r;
  logic [31:0] stat_r;
  logic [31:0] eaddr_r;
  logic [31:0] cctl_r;
  logic [31:0] sum_r;
  logic [31:0] xor_r;
  logic        busy_r;
  logic        hready_r;
  logic        rd_pend_r;
  logic        wr_pend_r;
  logic [15:0] acc_off_r;
  logic [31:0] hrdata_r;
  dce_state_t  st_r;
  logic        dv_r;
  logic [31:0] dd_r;
  logic [31:0] da_r;
  logic        ds_r;
  logic [2:0]  dc_r;
  logic        dl_r;

  // Bus access decode
  logic        acc;
  logic [15:0] base_off;
  logic [3:0]  alias_off;
  logic [31:0] cctl_nxt;
  logic [31:0] rd_mux;

  assign acc       = hsel && htrans[1] && hready;
  assign base_off  = {acc_off_r[15:4], 4'h0};
  assign alias_off = acc_off_r[3:0];

  function automatic logic [31:0] alias_wr(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  al,
                                           input logic [31:0] msk);
    logic [31:0] b;
    b = wd & msk;
    unique case (al)
      DCE_ALIAS_CLR: alias_wr = old & ~b;
      DCE_ALIAS_SET: alias_wr = old | b;
      DCE_ALIAS_INV: alias_wr = old ^ b;
      default:       alias_wr = (old & ~msk) | b;
    endcase
  endfunction : alias_wr

  function automatic logic [31:0] byte_order(input logic [31:0] d,
                                             input logic [1:0]  bo);
    unique case (bo)
      DCE_BORD_REV: byte_order = {d[7:0], d[15:8], d[23:16], d[31:24]};
      DCE_BORD_HSW: byte_order = {d[15:0], d[31:16]};
      DCE_BORD_BSW: byte_order = {d[23:16], d[31:24], d[7:0], d[15:8]};
      default:      byte_order = d;
    endcase
  endfunction : byte_order

  // Bit-serial Galois LFSR over one word, MSB first
  function automatic logic [31:0] lfsr_word(input logic [31:0] crc,
                                            input logic [31:0] d,
                                            input logic [31:0] taps,
                                            input logic [4:0]  polynomial_length_field);
    logic [31:0] c;
    logic [31:0] m;
    logic        fb;
    c  = crc;
    fb = 1'b0;
    m  = (polynomial_length_field == 5'd31) ? DCE_FULL_MASK
                         : ((32'h0000_0001 << (polynomial_length_field + 5'd1)) - 32'h1);
    for (int i = 31; i >= 0; i--) begin
      fb = c[polynomial_length_field] ^ d[i];
      c  = c << 1;
      if (fb) begin
        c = c ^ taps;
      end
      c = c & m;
    end
    lfsr_word = c;
  endfunction : lfsr_word

  // Ones-complement accumulate of two halfwords
  function automatic logic [31:0] ip_word(input logic [31:0] acc_v,
                                          input logic [31:0] d);
    logic [17:0] s;
    s = {2'b00, acc_v[15:0]} + {2'b00, d[31:16]} + {2'b00, d[15:0]};
    s = {2'b00, s[15:0]} + {16'h0000, s[17:16]};
    s = {2'b00, s[15:0]} + {16'h0000, s[17:16]};
    ip_word = {16'h0000, s[15:0]};
  endfunction : ip_word

  always_comb begin
    cctl_nxt = alias_wr(cctl_r, hwdata, alias_off, DCE_CCTL_WMASK);
    if (cctl_nxt[DCE_CCTL_WRORD]) begin
      cctl_nxt[DCE_CCTL_APP] = 1'b0;
    end
  end

  always_comb begin
    rd_mux = DCE_REG_RESET;
    if (alias_off == DCE_ALIAS_NONE) begin
      unique case (base_off)
        DCE_OFF_GCTL:  rd_mux = gctl_r | (32'(busy_r) << DCE_GCTL_BUSY);
        DCE_OFF_STAT:  rd_mux = stat_r;
        DCE_OFF_EADDR: rd_mux = eaddr_r;
        DCE_OFF_CCTL:  rd_mux = cctl_r;
        DCE_OFF_CDATA: rd_mux = sum_r;
        DCE_OFF_CXOR:  rd_mux = xor_r;
        default:       rd_mux = DCE_REG_RESET;
      endcase
    end
  end

  // AHB-Lite slave: zero-wait writes, one wait state on reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_r  <= 1'b1;
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      acc_off_r <= '0;
      hrdata_r  <= DCE_REG_RESET;
    end else begin
      wr_pend_r <= acc && hwrite && (hsize == DCE_HSIZE_WORD);
      if (acc) begin
        acc_off_r <= haddr[15:0];
      end
      if (acc && !hwrite) begin
        rd_pend_r <= 1'b1;
        hready_r  <= 1'b0;
      end else if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        hready_r  <= 1'b1;
        hrdata_r  <= rd_mux;
      end
    end
  end

  logic wr_gctl;
  logic wr_cctl;
  logic wr_cdata;
  logic wr_cxor;
  assign wr_gctl  = wr_pend_r && (base_off == DCE_OFF_GCTL);
  assign wr_cctl  = wr_pend_r && (base_off == DCE_OFF_CCTL);
  assign wr_cdata = wr_pend_r && (base_off == DCE_OFF_CDATA);
  assign wr_cxor  = wr_pend_r && (base_off == DCE_OFF_CXOR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gctl_r <= DCE_REG_RESET;
      cctl_r <= DCE_REG_RESET;
      xor_r  <= DCE_REG_RESET;
    end else begin
      if (wr_gctl) begin
        gctl_r <= alias_wr(gctl_r, hwdata, alias_off, DCE_GCTL_WMASK);
      end
      if (wr_cctl) begin
        cctl_r <= cctl_nxt;
      end
      if (wr_cxor) begin
        xor_r <= alias_wr(xor_r, hwdata, alias_off, DCE_FULL_MASK);
      end
    end
  end

  // Error capture from the transfer engine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r  <= DCE_REG_RESET;
      eaddr_r <= DCE_REG_RESET;
    end else if (err_valid) begin
      stat_r  <= (32'(err_write) << DCE_STAT_DIR)
               | (32'(err_chan) << DCE_STAT_CH_LO);
      eaddr_r <= err_addr;
    end
  end

  // Input buffer
  assign in_if.valid = src_valid;
  assign in_if.data  = {src_last, src_chan, src_data};
  assign src_ready   = in_if.ready;

  dce_fifo #(.W(DCE_WORD_W), .DEPTH(DCE_FIFO_DEPTH)) u_fifo (
    .clk  (hclk),
    .rstn (hresetn),
    .wr   (in_if.snk),
    .rd   (out_if.src)
  );

  // Drain stage
  logic        run;
  logic        out_free;
  logic        drain;
  logic        w_last;
  logic [2:0]  w_ch;
  logic [31:0] w_data;
  logic        sel;
  logic        app;
  logic [31:0] crc_in;
  logic [31:0] sum_upd;
  logic [31:0] fwd_data;
  logic [31:0] result;

  assign run      = gctl_r[DCE_GCTL_ON] && !gctl_r[DCE_GCTL_SUSP];
  assign out_free = !dv_r || dst_ready;
  assign out_if.ready = (st_r == DCE_ST_RUN) && run && out_free;
  assign drain    = out_if.ready && out_if.valid;
  assign {w_last, w_ch, w_data} = out_if.data;
  assign sel      = cctl_r[DCE_CCTL_EN]
                  && (w_ch == cctl_r[DCE_CCTL_CH +: DCE_CH_W]);
  assign app      = cctl_r[DCE_CCTL_APP];

  always_comb begin
    crc_in = byte_order(w_data, cctl_r[DCE_CCTL_BORD +: 2]);
    if (cctl_r[DCE_CCTL_BREV]) begin
      crc_in = {<<{crc_in}};
    end
    if (cctl_r[DCE_CCTL_TYP]) begin
      sum_upd = ip_word(sum_r, crc_in);
    end else begin
      sum_upd = lfsr_word(sum_r, crc_in, xor_r,
                          cctl_r[DCE_CCTL_POLY +: 5]);
    end
  end

  assign fwd_data = cctl_r[DCE_CCTL_WRORD]
                  ? byte_order(w_data, DCE_BORD_REV) : w_data;
  assign result   = cctl_r[DCE_CCTL_TYP] ? {16'h0000, ~sum_r[15:0]} : sum_r;

  // Running checksum; engine update wins over a bus write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum_r <= DCE_REG_RESET;
    end else if (drain && sel) begin
      sum_r <= sum_upd;
    end else if (wr_cdata) begin
      sum_r <= alias_wr(sum_r, hwdata, alias_off, DCE_FULL_MASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= DCE_ST_RUN;
    end else begin
      unique case (st_r)
        DCE_ST_RUN: begin
          if (drain && sel && app && w_last) begin
            st_r <= DCE_ST_EMIT;
          end
        end
        DCE_ST_EMIT: begin
          if (out_free) begin
            st_r <= DCE_ST_RUN;
          end
        end
        default: st_r <= DCE_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv_r <= 1'b0;
      dd_r <= '0;
      da_r <= '0;
      ds_r <= 1'b0;
      dc_r <= '0;
      dl_r <= 1'b0;
    end else if ((st_r == DCE_ST_EMIT) && out_free) begin
      dv_r <= 1'b1;
      dd_r <= result;
      da_r <= dst_start_addr;
      ds_r <= 1'b1;
      dc_r <= cctl_r[DCE_CCTL_CH +: DCE_CH_W];
      dl_r <= 1'b1;
    end else if (drain && !(sel && app)) begin
      dv_r <= 1'b1;
      dd_r <= sel ? fwd_data : w_data;
      da_r <= '0;
      ds_r <= 1'b0;
      dc_r <= w_ch;
      dl_r <= w_last;
    end else if (dst_ready) begin
      dv_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= out_if.valid || dv_r || (st_r == DCE_ST_EMIT);
    end
  end

  assign hreadyout  = hready_r;
  assign hresp      = DCE_HRESP_OKAY;
  assign hrdata     = hrdata_r;
  assign dst_valid  = dv_r;
  assign dst_data   = dd_r;
  assign dst_addr   = da_r;
  assign dst_is_sum = ds_r;
  assign dst_chan   = dc_r;
  assign dst_last   = dl_r;

  // Checks
  sequence s_app_end;
    drain && sel && app && w_last;
  endsequence
  sequence s_emit;
    (st_r == DCE_ST_EMIT) && out_free;
  endsequence

  AST_APP_NO_FWD: assert property (
    drain && sel && app |=> !(dv_r && !ds_r))
    else $error("append mode forwarded data");
  AST_APP_SUM: assert property (
    s_app_end ##1 s_emit |=> dv_r && ds_r && dd_r == $past(result)
      && da_r == $past(dst_start_addr))
    else $error("checksum not written at block end");
  AST_PASS: assert property (
    drain && sel && !app |=> dv_r && !ds_r && dd_r == $past(fwd_data))
    else $error("pass-through data wrong");
  AST_IP_TYPE: assert property (
    drain && sel && cctl_r[DCE_CCTL_TYP] |=> sum_r[31:16] == 16'h0000)
    else $error("ip checksum upper half not zero");
  AST_CH_OTHER: assert property (
    drain && !sel && !wr_cdata |=> dv_r && dd_r == $past(w_data)
      && $stable(sum_r))
    else $error("unselected channel altered");
  AST_WORDER_APP: assert property (
    cctl_r[DCE_CCTL_WRORD] |-> !cctl_r[DCE_CCTL_APP])
    else $error("append set while write byte order set");
  AST_ALIAS_SET: assert property (
    wr_gctl && alias_off == DCE_ALIAS_SET |=>
      gctl_r == ($past(gctl_r) | ($past(hwdata) & DCE_GCTL_WMASK)))
    else $error("set alias wrong");
  AST_ALIAS_INV: assert property (
    wr_cxor && alias_off == DCE_ALIAS_INV |=>
      xor_r == ($past(xor_r) ^ $past(hwdata)))
    else $error("invert alias wrong");
  AST_RESET_ZERO: assert property (@(posedge hclk)
    $rose(hresetn) |-> gctl_r == 32'h0 && cctl_r == 32'h0 && sum_r == 32'h0
      && stat_r == 32'h0 && eaddr_r == 32'h0)
    else $error("register not zero after reset");
  AST_UNIMPL: assert property (
    (cctl_r & ~DCE_CCTL_WMASK) == 32'h0 && (gctl_r & ~DCE_GCTL_WMASK) == 32'h0)
    else $error("unimplemented bit set");
  AST_SUM_HOLD: assert property (
    !(drain && sel) && !wr_cdata |=> $stable(sum_r))
    else $error("running checksum changed");
endmodule : dce_engine
`default_nettype wire

// *** tb_dma_crc_engine.sv ***
// Self-checking bench for the DMA checksum engine top, dce_engine.
// Assumes a single AHB-Lite master and a bench-driven stream source/sink.
`timescale 1ns/10ps
`default_nettype none
module tb_dma_crc_engine
  import dce_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, src_data, dst_start_addr, err_addr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, src_chan, err_chan, dst_chan;
  logic        hreadyout, hresp, src_valid, src_ready, src_last, dst_valid;
  logic        dst_ready, dst_is_sum, dst_last, err_valid, err_write;
  logic [31:0] dst_data, dst_addr;
  wire  logic  hready;
  logic        stall_mode;
  int          n_mismatch, tests_run, cycles;
  logic [31:0] q_data[$], q_addr[$];
  logic [4:0]  q_flag[$];

  assign hready = hreadyout;

  dce_engine uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .src_valid(src_valid),
    .src_ready(src_ready), .src_data(src_data), .src_chan(src_chan),
    .src_last(src_last), .dst_start_addr(dst_start_addr),
    .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data),
    .dst_addr(dst_addr), .dst_is_sum(dst_is_sum), .dst_chan(dst_chan),
    .dst_last(dst_last), .err_valid(err_valid), .err_write(err_write),
    .err_chan(err_chan), .err_addr(err_addr));

  always #2.5 hclk = ~hclk;

  // Sink: steady or toggling accept, captures every accepted word
  always @(posedge hclk) begin
    dst_ready <= stall_mode ? ~dst_ready : 1'b1;
    if (dst_valid === 1'b1 && dst_ready === 1'b1) begin
      q_data.push_back(dst_data);
      q_addr.push_back(dst_addr);
      q_flag.push_back({dst_is_sum, dst_last, dst_chan});
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic ahb_write(input logic [15:0] a, input logic [31:0] d);
    haddr  <= {16'h0000, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : ahb_write

  task automatic ahb_read(input logic [15:0] a, output logic [31:0] d);
    haddr  <= {16'h0000, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : ahb_read

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    ahb_read(a, d);
    chk(d, exp);
  endtask : rd_chk

  // Leaves the word valid; caller drops it with src_idle
  task automatic push(input logic [31:0] d, input logic [2:0] ch,
                      input logic l);
    src_valid <= 1'b1;
    src_data  <= d;
    src_chan  <= ch;
    src_last  <= l;
    do @(posedge hclk); while (src_ready !== 1'b1);
  endtask : push

  task automatic src_idle();
    src_valid <= 1'b0;
    src_last  <= 1'b0;
    @(posedge hclk);
  endtask : src_idle

  task automatic wait_out(input int n);
    for (int i = 0; i < 300 && q_data.size() < n; i++) @(posedge hclk);
    chk(32'(q_data.size()), 32'(n));
  endtask : wait_out

  task automatic chk_out(input int i, input logic [31:0] d,
                         input logic [31:0] a, input logic [4:0] f);
    chk(q_data[i], d);
    chk(q_addr[i], a);
    chk({27'h0, q_flag[i]}, {27'h0, f});
  endtask : chk_out

  function automatic logic [31:0] lfsr(input logic [31:0] c,
      input logic [31:0] d, input logic [31:0] t);
    logic fb;
    for (int i = 31; i >= 0; i--) begin
      fb = c[31] ^ d[i];
      c = c << 1;
      if (fb) c = c ^ t;
    end
    return c;
  endfunction : lfsr

  task automatic t_reset_values();
    chk({31'h0, hresp}, 32'h0000_0000);
    rd_chk(DCE_OFF_GCTL, 32'h0000_0000);
    rd_chk(DCE_OFF_STAT, 32'h0000_0000);
    rd_chk(DCE_OFF_EADDR, 32'h0000_0000);
    rd_chk(DCE_OFF_CCTL, 32'h0000_0000);
    rd_chk(DCE_OFF_CDATA, 32'h0000_0000);
    rd_chk(DCE_OFF_CXOR, 32'h0000_0000);
    rd_chk(16'h3060, 32'h0000_0000);
  endtask : t_reset_values

  task automatic t_alias();
    ahb_write(DCE_OFF_CCTL, 32'hFFFF_FFFF);
    rd_chk(DCE_OFF_CCTL, 32'h3900_1FA7);
    ahb_write(16'h3034, 32'h0800_0000);
    rd_chk(DCE_OFF_CCTL, 32'h3100_1FA7);
    ahb_write(16'h3038, 32'h0000_0040);
    rd_chk(DCE_OFF_CCTL, 32'h3100_1FE7);
    ahb_write(16'h303C, 32'h0000_00FF);
    rd_chk(DCE_OFF_CCTL, 32'h3100_1F00);
    ahb_write(16'h3008, 32'hFFFF_FFFF);
    rd_chk(DCE_OFF_GCTL, 32'h0000_9000);
    ahb_write(16'h3004, 32'hFFFF_FFFF);
    rd_chk(DCE_OFF_GCTL, 32'h0000_0000);
    ahb_write(DCE_OFF_CCTL, 32'h0800_0000);
    ahb_write(16'h3038, 32'h0000_0040);
    rd_chk(DCE_OFF_CCTL, 32'h0800_0000);
    rd_chk(16'h3034, 32'h0000_0000);
  endtask : t_alias

  task automatic t_fill_pass();
    ahb_write(DCE_OFF_CDATA, 32'h0000_0000);
    ahb_write(DCE_OFF_CCTL, 32'h0800_00A3);
    push(32'h1122_3344, 3'h3, 1'b0);
    push(32'hA5A5_0001, 3'h2, 1'b0);
    push(32'h0102_0304, 3'h3, 1'b0);
    push(32'h5A5A_0002, 3'h2, 1'b0);
    src_idle();
    chk({31'h0, src_ready}, 32'h0000_0000);
    stall_mode = 1'b1;
    ahb_write(16'h3008, 32'h0000_8000);
    wait_out(4);
    chk_out(0, 32'h4433_2211, 32'h0, 5'h03);
    chk_out(1, 32'hA5A5_0001, 32'h0, 5'h02);
    chk_out(2, 32'h0403_0201, 32'h0, 5'h03);
    chk_out(3, 32'h5A5A_0002, 32'h0, 5'h02);
    rd_chk(DCE_OFF_CDATA, 32'h0000_486C);
    stall_mode = 1'b0;
  endtask : t_fill_pass

  task automatic t_append_ip();
    q_data.delete(); q_addr.delete(); q_flag.delete();
    ahb_write(DCE_OFF_CDATA, 32'h0000_0000);
    ahb_write(DCE_OFF_CCTL, 32'h0000_00E5);
    push(32'hCAFE_0000, 3'h4, 1'b0);
    push(32'h0001_0002, 3'h5, 1'b0);
    push(32'hFFFF_0001, 3'h5, 1'b1);
    src_idle();
    wait_out(2);
    chk_out(0, 32'hCAFE_0000, 32'h0, 5'h04);
    chk_out(1, 32'h0000_FFFB, 32'h2000_0100, 5'h1D);
  endtask : t_append_ip

  task automatic t_append_lfsr();
    logic [31:0] exp;
    exp = lfsr(32'h0, 32'h1234_5678, 32'h04C1_1DB7);
    q_data.delete(); q_addr.delete(); q_flag.delete();
    ahb_write(DCE_OFF_CDATA, 32'h0000_0000);
    ahb_write(DCE_OFF_CXOR, 32'h04C1_1DB7);
    ahb_write(DCE_OFF_CCTL, 32'h0000_1FC1);
    push(32'h1234_5678, 3'h1, 1'b1);
    src_idle();
    wait_out(1);
    chk_out(0, exp, 32'h2000_0100, 5'h19);
    rd_chk(DCE_OFF_CDATA, exp);
    rd_chk(DCE_OFF_CXOR, 32'h04C1_1DB7);
  endtask : t_append_lfsr

  // Suspend holds the word; then reversed bytes and bits feed the sum
  task automatic t_suspend_order();
    q_data.delete(); q_addr.delete(); q_flag.delete();
    ahb_write(DCE_OFF_CDATA, 32'h0000_0000);
    ahb_write(DCE_OFF_CCTL, 32'h1100_00A0);
    ahb_write(16'h3008, 32'h0000_1000);
    push(32'h1122_3344, 3'h0, 1'b0);
    src_idle();
    repeat (4) @(posedge hclk);
    chk(32'(q_data.size()), 32'h0000_0000);
    rd_chk(DCE_OFF_GCTL, 32'h0000_9800);
    ahb_write(16'h3004, 32'h0000_1000);
    wait_out(1);
    chk_out(0, 32'h1122_3344, 32'h0, 5'h00);
    rd_chk(DCE_OFF_CDATA, 32'h0000_5467);
  endtask : t_suspend_order

  task automatic t_error_capture();
    err_valid <= 1'b1;
    err_write <= 1'b1;
    err_chan  <= 3'h6;
    err_addr  <= 32'hDEAD_BEEF;
    @(posedge hclk);
    err_valid <= 1'b0;
    @(posedge hclk);
    rd_chk(DCE_OFF_STAT, 32'h0000_000E);
    rd_chk(DCE_OFF_EADDR, 32'hDEAD_BEEF);
    ahb_write(DCE_OFF_STAT, 32'h0000_0000);
    rd_chk(DCE_OFF_STAT, 32'h0000_000E);
  endtask : t_error_capture

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b1; hwrite = 1'b0;
    haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = DCE_HSIZE_WORD;
    src_valid = 1'b0; src_data = 32'h0; src_chan = 3'h0; src_last = 1'b0;
    dst_start_addr = 32'h2000_0100; stall_mode = 1'b0;
    err_valid = 1'b0; err_write = 1'b0; err_chan = 3'h0; err_addr = 32'h0;
    n_mismatch = 0; tests_run = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_alias();
    t_fill_pass();
    t_append_ip();
    t_append_lfsr();
    t_suspend_order();
    t_error_capture();
    print_verdict();
  end
endmodule : tb_dma_crc_engine
`default_nettype wire
